/* fccd_pkg.sv */
// Constants and types for the fp compare/convert/divide and fetch decoder.
// Assumes an APB slave with 32-bit data and byte addresses.
package fccd_pkg;

  // Upper opcode bytes, the fetch prefix of bits 15 to 10, and the status-word code of bits 7 to 4
  localparam logic [7:0] OP_CMPQ_S = 8'hca;
  localparam logic [7:0] OP_CMPQ_D = 8'hcb;
  localparam logic [7:0] OP_NARROW = 8'hcc;
  localparam logic [7:0] OP_WIDEN = 8'hcd;
  localparam logic [7:0] OP_DIV_S = 8'hc6;
  localparam logic [7:0] OP_DIV_D = 8'hc7;
  localparam logic [5:0] OP_FETCH = 6'h2e;
  localparam logic [3:0] STATUS_WORD_CODE = 4'h1;

  // Instruction fields
  localparam int unsigned INS_BANK = 9;
  localparam int unsigned INS_N_HI = 8;

  // Register byte offsets
  localparam logic [11:0] ADDR_INSTR = 12'h000;
  localparam logic [11:0] ADDR_DECODE = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_EXC = 12'h00c;
  localparam logic [11:0] ADDR_RES_HI = 12'h010;
  localparam logic [11:0] ADDR_RES_LO = 12'h014;
  localparam logic [11:0] ADDR_COMMIT = 12'h018;
  localparam logic [11:0] ADDR_PREFETCH = 12'h01c;
  localparam logic [11:0] ADDR_LREG = 12'h100;
  localparam logic [11:0] ADDR_LREG_END = 12'h13c;

  // Condition flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;

  // Exception bit positions
  localparam int unsigned EXC_INVALID = 0;
  localparam int unsigned EXC_DIVZERO = 1;
  localparam int unsigned EXC_OVERFLOW = 2;
  localparam int unsigned EXC_UNDERFLOW = 3;
  localparam int unsigned EXC_INEXACT = 4;

  // Commit word layout
  localparam int unsigned COMMIT_EQ = 0;
  localparam int unsigned COMMIT_LT = 1;
  localparam int unsigned COMMIT_EXC_LSB = 8;

  // Decode status layout
  localparam int unsigned DEC_OP_LSB = 8;
  localparam int unsigned DEC_BANK = 12;
  localparam int unsigned DEC_N_LSB = 13;
  localparam int unsigned DEC_UNORD = 18;
  localparam int unsigned DEC_EMU = 19;
  localparam int unsigned DEC_STALL = 20;

  // Reset values
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [4:0] EXC_RST = 5'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Double compare raises invalid on unordered when set
  localparam logic DCMP_RAISES_INVALID = 1'b0;

  typedef enum logic [3:0] {
    OPC_NONE,
    OPC_CMP_S,
    OPC_CMP_D,
    OPC_NARROW,
    OPC_WIDEN,
    OPC_DIV_S,
    OPC_DIV_D,
    OPC_FETCH,
    OPC_CONDSET
  } fccd_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EMU,
    ST_FETCH
  } fccd_state_t;

endpackage

/* fccd_decoder.sv */
// Decoder and emulation hand-off for fp compare, convert, divide and fetch.
// Assumes an APB master, software emulation, and a prefetch count from the cache.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module fccd_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] prefetch_halfwords,
  output logic emu_req,
  output logic fetch_stall
);

  logic [15:0] instr;
  fccd_pkg::fccd_op_t op;
  logic [3:0] dest;
  logic [3:0] src;
  logic bank;
  logic [4:0] wait_n;
  logic [3:0] flags;
  logic [4:0] exc;
  logic [31:0] res_hi;
  logic [31:0] res_lo;
  logic [31:0] lreg [16];
  fccd_pkg::fccd_state_t state;
  fccd_pkg::fccd_state_t next_state;

  logic acc;
  logic wr;
  logic rd_unmapped;
  logic is_lreg;
  logic [3:0] lreg_idx;
  logic issue;
  logic commit;
  logic bad_issue;
  logic bad_commit;
  logic unordered;
  logic cmp_eq;
  logic cmp_lt;
  logic [4:0] commit_exc;
  logic [4:0] exc_set;
  logic [5:0] fetch_need;
  fccd_pkg::fccd_op_t dec_op;

  // Decoding used on issue
  function automatic fccd_pkg::fccd_op_t decode_op(input logic [15:0] ins);
    fccd_pkg::fccd_op_t r;
    r = fccd_pkg::OPC_NONE;
    case (ins[15:8])
      fccd_pkg::OP_CMPQ_S: r = fccd_pkg::OPC_CMP_S;
      fccd_pkg::OP_CMPQ_D: r = fccd_pkg::OPC_CMP_D;
      fccd_pkg::OP_NARROW: r = fccd_pkg::OPC_NARROW;
      fccd_pkg::OP_WIDEN: r = fccd_pkg::OPC_WIDEN;
      fccd_pkg::OP_DIV_S: r = fccd_pkg::OPC_DIV_S;
      fccd_pkg::OP_DIV_D: r = fccd_pkg::OPC_DIV_D;
      default: begin
        if (ins[15:10] == fccd_pkg::OP_FETCH) begin
          // Status word is global register one, so only bank clear can name it
          if (!ins[fccd_pkg::INS_BANK] && ins[7:4] == fccd_pkg::STATUS_WORD_CODE) begin
            r = fccd_pkg::OPC_FETCH;
          end else begin
            r = fccd_pkg::OPC_CONDSET;
          end
        end
      end
    endcase
    return r;
  endfunction

  // Exponent-word quiet-NaN test: bits 30 to 19 all set
  function automatic logic is_nan(input logic [31:0] w);
    return &w[30:19];
  endfunction

  // Low word of a double sits in the following local register
  function automatic logic [3:0] pair_low(input logic [3:0] idx);
    return idx + 4'h1;
  endfunction

  function automatic logic emulated(input fccd_pkg::fccd_op_t o);
    return o inside {fccd_pkg::OPC_CMP_S, fccd_pkg::OPC_CMP_D, fccd_pkg::OPC_NARROW,
                     fccd_pkg::OPC_WIDEN, fccd_pkg::OPC_DIV_S, fccd_pkg::OPC_DIV_D};
  endfunction

  function automatic logic is_double_dest(input fccd_pkg::fccd_op_t o);
    return o inside {fccd_pkg::OPC_WIDEN, fccd_pkg::OPC_DIV_D};
  endfunction

  function automatic logic is_cmp(input fccd_pkg::fccd_op_t o);
    return o inside {fccd_pkg::OPC_CMP_S, fccd_pkg::OPC_CMP_D};
  endfunction

  // Bus decode; the slave never inserts wait states
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign is_lreg = paddr >= fccd_pkg::ADDR_LREG && paddr <= fccd_pkg::ADDR_LREG_END;
  assign lreg_idx = paddr[5:2];
  assign dec_op = decode_op(pwdata[15:0]);
  assign issue = wr && paddr == fccd_pkg::ADDR_INSTR && state == fccd_pkg::ST_IDLE;
  assign bad_issue = wr && paddr == fccd_pkg::ADDR_INSTR && state != fccd_pkg::ST_IDLE;
  assign commit = wr && paddr == fccd_pkg::ADDR_COMMIT && state == fccd_pkg::ST_EMU;
  assign bad_commit = wr && paddr == fccd_pkg::ADDR_COMMIT && state != fccd_pkg::ST_EMU;

  always_comb begin
    case (paddr)
      fccd_pkg::ADDR_INSTR,
      fccd_pkg::ADDR_DECODE,
      fccd_pkg::ADDR_FLAGS,
      fccd_pkg::ADDR_EXC,
      fccd_pkg::ADDR_RES_HI,
      fccd_pkg::ADDR_RES_LO,
      fccd_pkg::ADDR_COMMIT,
      fccd_pkg::ADDR_PREFETCH: rd_unmapped = 1'b0;
      default: rd_unmapped = !(is_lreg && paddr[1:0] == 2'b00);
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = acc && (rd_unmapped || bad_issue || bad_commit);

  // Both exponent words are the named registers, single or double alike
  assign unordered = is_nan(lreg[dest]) || is_nan(lreg[src]);
  assign cmp_eq = pwdata[fccd_pkg::COMMIT_EQ];
  assign cmp_lt = pwdata[fccd_pkg::COMMIT_LT];
  assign commit_exc = pwdata[fccd_pkg::COMMIT_EXC_LSB +: 5];
  assign fetch_need = {2'b00, wait_n[4:1]} + 6'h01;

  // Exceptions reported by this commit
  always_comb begin
    exc_set = 5'h00;
    if (commit) begin
      if (is_cmp(op)) begin
        if (op == fccd_pkg::OPC_CMP_D && fccd_pkg::DCMP_RAISES_INVALID && unordered) begin
          exc_set[fccd_pkg::EXC_INVALID] = 1'b1;
        end
      end else begin
        exc_set = commit_exc;
      end
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      fccd_pkg::ST_IDLE: begin
        if (issue && emulated(dec_op)) begin
          next_state = fccd_pkg::ST_EMU;
        end else if (issue && dec_op == fccd_pkg::OPC_FETCH) begin
          next_state = fccd_pkg::ST_FETCH;
        end
      end
      fccd_pkg::ST_EMU: begin
        if (commit) begin
          next_state = fccd_pkg::ST_IDLE;
        end
      end
      fccd_pkg::ST_FETCH: begin
        if (prefetch_halfwords >= fetch_need) begin
          next_state = fccd_pkg::ST_IDLE;
        end
      end
      default: next_state = fccd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fccd_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Instruction latch and field split
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= fccd_pkg::INSTR_RST;
      op <= fccd_pkg::OPC_NONE;
      dest <= 4'h0;
      src <= 4'h0;
      bank <= 1'b0;
      wait_n <= 5'h00;
    end else if (issue) begin
      instr <= pwdata[15:0];
      op <= dec_op;
      dest <= pwdata[7:4];
      src <= pwdata[3:0];
      bank <= pwdata[fccd_pkg::INS_BANK];
      wait_n <= {pwdata[fccd_pkg::INS_N_HI], pwdata[3:0]};
    end
  end

  // Condition flags change on a compare commit or on a write to the flags register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= fccd_pkg::FLAGS_RST;
    end else if (commit && is_cmp(op)) begin
      flags[fccd_pkg::FLAG_Z] <= cmp_eq && !unordered;
      flags[fccd_pkg::FLAG_N] <= cmp_lt || unordered;
      flags[fccd_pkg::FLAG_C] <= cmp_lt && !unordered;
      flags[fccd_pkg::FLAG_V] <= unordered;
    end else if (wr && paddr == fccd_pkg::ADDR_FLAGS) begin
      flags <= pwdata[3:0];
    end
  end

  // Sticky exceptions, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc <= fccd_pkg::EXC_RST;
    end else if (wr && paddr == fccd_pkg::ADDR_EXC) begin
      exc <= (exc & ~pwdata[4:0]) | exc_set;
    end else begin
      exc <= exc | exc_set;
    end
  end

  // Result staging written by the emulation routine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_hi <= fccd_pkg::WORD_RST;
      res_lo <= fccd_pkg::WORD_RST;
    end else if (wr && paddr == fccd_pkg::ADDR_RES_HI) begin
      res_hi <= pwdata;
    end else if (wr && paddr == fccd_pkg::ADDR_RES_LO) begin
      res_lo <= pwdata;
    end
  end

  // Local registers; commit writes only the destination word or pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        lreg[i] <= fccd_pkg::WORD_RST;
      end
    end else if (commit && !is_cmp(op)) begin
      lreg[dest] <= res_hi;
      if (is_double_dest(op)) begin
        lreg[pair_low(dest)] <= res_lo;
      end
    end else if (wr && is_lreg && paddr[1:0] == 2'b00) begin
      lreg[lreg_idx] <= pwdata;
    end
  end

  // Read data is registered at the setup cycle so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= fccd_pkg::WORD_RST;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        fccd_pkg::ADDR_INSTR: prdata[15:0] <= instr;
        fccd_pkg::ADDR_DECODE: begin
          prdata[3:0] <= src;
          prdata[7:4] <= dest;
          prdata[fccd_pkg::DEC_OP_LSB +: 4] <= op;
          prdata[fccd_pkg::DEC_BANK] <= bank;
          prdata[fccd_pkg::DEC_N_LSB +: 5] <= wait_n;
          prdata[fccd_pkg::DEC_UNORD] <= unordered;
          prdata[fccd_pkg::DEC_EMU] <= state == fccd_pkg::ST_EMU;
          prdata[fccd_pkg::DEC_STALL] <= state == fccd_pkg::ST_FETCH;
        end
        fccd_pkg::ADDR_FLAGS: prdata[3:0] <= flags;
        fccd_pkg::ADDR_EXC: prdata[4:0] <= exc;
        fccd_pkg::ADDR_RES_HI: prdata <= res_hi;
        fccd_pkg::ADDR_RES_LO: prdata <= res_lo;
        fccd_pkg::ADDR_PREFETCH: prdata[5:0] <= prefetch_halfwords;
        default: begin
          if (is_lreg && paddr[1:0] == 2'b00) begin
            prdata <= lreg[lreg_idx];
          end
        end
      endcase
    end
  end

  // Straight from the state flop
  assign emu_req = state == fccd_pkg::ST_EMU;
  assign fetch_stall = state == fccd_pkg::ST_FETCH;

endmodule

/* fccd_decoder_assertions.sv */
// Port checker for the fccd decoder.
// Sees only the decoder's ports; bound to every instance.
`timescale 1ns/10ps
module fccd_decoder_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] prefetch_halfwords,
  input wire logic emu_req,
  input wire logic fetch_stall
);
  logic acc;
  logic iss;
  logic cmt;
  logic [5:0] thr;
  assign acc = psel && penable && pwrite;
  assign iss = acc && paddr == fccd_pkg::ADDR_INSTR && !pslverr;
  assign cmt = acc && paddr == fccd_pkg::ADDR_COMMIT;
  // Bit 0 of the count is dropped on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr <= 6'h01;
    end else if (iss) begin
      thr <= {2'b00, pwdata[8], pwdata[3:1]} + 6'h01;
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  fp_emu_a: assert property (iss && pwdata[15:8] inside
    {8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc6, 8'hc7} |=> emu_req && !fetch_stall)
    else $error("fp issue gave no emulation request");
  fetch_stall_a: assert property (iss && pwdata[15:9] == 7'h5c
    && pwdata[7:4] == 4'h1 |=> fetch_stall)
    else $error("fetch issue gave no stall");
  condset_idle_a: assert property (iss && pwdata[15:10] == 6'h2e
    && (pwdata[9] || pwdata[7:4] != 4'h1) |=> !fetch_stall && !emu_req)
    else $error("conditional set stalled");
  stall_hold_a: assert property (fetch_stall && prefetch_halfwords < thr
    |=> fetch_stall)
    else $error("stall ended too early");
  stall_release_a: assert property (fetch_stall && prefetch_halfwords >= thr
    |=> !fetch_stall)
    else $error("stall not released");
  busy_refuse_a: assert property (acc && paddr == fccd_pkg::ADDR_INSTR
    && (emu_req || fetch_stall) |-> pslverr)
    else $error("issue while busy accepted");
  emu_hold_a: assert property (emu_req && !cmt |=> emu_req)
    else $error("emulation request dropped");
  emu_done_a: assert property (emu_req && cmt |=> !emu_req)
    else $error("commit left request high");
endmodule

bind fccd_decoder fccd_decoder_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .prefetch_halfwords(prefetch_halfwords),
  .emu_req(emu_req), .fetch_stall(fetch_stall));

/* test_fccd_decoder.sv */
// Self-checking bench for the fccd decoder.
// Drives every input port, the APB ones as an APB master, and waits for pready until the 5000-cycle ceiling.
`timescale 1ns/10ps
module test_fccd_decoder;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [5:0] prefetch_halfwords = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic emu_req;
  logic fetch_stall;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] r;
  logic u;
  logic [3:0] fl;
  logic [31:0] dv [4] = '{32'h3f80_0000, 32'h7ff8_0000, 32'h7ff7_ffff, 32'h0000_0000};
  logic [31:0] sv [4] = '{32'h4000_0000, 32'h0000_0000, 32'h0000_0000, 32'hfff8_0000};
  logic [1:0] cv [4] = '{2'h2, 2'h1, 2'h1, 2'h3};
  logic [7:0] ops [4] = '{8'hcc, 8'hcd, 8'hc6, 8'hc7};
  logic [3:0] dst [4] = '{4'h5, 4'hf, 4'h7, 4'h7};
  logic [15:0] cs [2] = '{16'hba16, 16'hb826};

  always #12.5 pclk = ~pclk;

  fccd_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prefetch_halfwords(prefetch_halfwords), .emu_req(emu_req),
    .fetch_stall(fetch_stall));

  function automatic logic nan(input logic [31:0] v);
    return (v & 32'h7ff8_0000) == 32'h7ff8_0000;
  endfunction

  function automatic logic [11:0] lr(input logic [3:0] k);
    return fccd_pkg::ADDR_LREG + {6'h00, k, 2'b00};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle edge after each transfer keeps drivers single per step
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    check({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0, 1'b0);
    check(r, exp);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(fccd_pkg::ADDR_FLAGS, 32'h0);
    xfer(12'h020, 1'b0, 32'h0, 1'b1);
    xfer(fccd_pkg::ADDR_COMMIT, 1'b1, 32'h1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr(lr(4'h2), dv[k]);
      wr(lr(4'h3), sv[k]);
      wr(fccd_pkg::ADDR_INSTR, {16'h0, k[0] ? 8'hcb : 8'hca, 8'h23});
      check({31'h0, emu_req}, 32'h1);
      u = nan(dv[k]) | nan(sv[k]);
      xfer(fccd_pkg::ADDR_DECODE, 1'b0, 32'h0, 1'b0);
      check(r & 32'hfff, {20'h0, k[0] ? 4'h2 : 4'h1, 8'h23});
      check(r & 32'h000c_0000, {12'h0, 1'b1, u, 18'h0});
      xfer(fccd_pkg::ADDR_INSTR, 1'b1, 32'h0, 1'b1);
      wr(fccd_pkg::ADDR_COMMIT, {19'h0, 5'h1f, 6'h0, cv[k]});
      fl = {u, cv[k][1] | u, cv[k][0] & !u, cv[k][1] & !u};
      rd(fccd_pkg::ADDR_FLAGS, {28'h0, fl});
    end
    rd(fccd_pkg::ADDR_EXC, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(lr(dst[k]), 32'haaaa_aaaa);
      wr(lr(dst[k] + 4'h1), 32'h5555_5555);
      wr(fccd_pkg::ADDR_INSTR, {16'h0, ops[k], dst[k], 4'h3});
      wr(fccd_pkg::ADDR_RES_HI, 32'h1000_0000 + 32'(k));
      wr(fccd_pkg::ADDR_RES_LO, 32'h2000_0000);
      wr(fccd_pkg::ADDR_COMMIT, {19'h0, 5'h03 << k, 8'h0});
      rd(lr(dst[k]), 32'h1000_0000 + 32'(k));
      rd(lr(dst[k] + 4'h1), k[0] ? 32'h2000_0000 : 32'h5555_5555);
      rd(fccd_pkg::ADDR_FLAGS, 32'hc);
    end
    rd(fccd_pkg::ADDR_EXC, 32'h1f);
    wr(fccd_pkg::ADDR_EXC, 32'h1);
    rd(fccd_pkg::ADDR_EXC, 32'h1e);
    wr(fccd_pkg::ADDR_INSTR, 32'hb916);
    rd(fccd_pkg::ADDR_DECODE, 32'h0012_c716);
    repeat (3) @(posedge pclk);
    check({31'h0, fetch_stall}, 32'h1);
    prefetch_halfwords <= 6'h0b;
    repeat (3) @(posedge pclk);
    check({31'h0, fetch_stall}, 32'h1);
    prefetch_halfwords <= 6'h0c;
    repeat (3) @(posedge pclk);
    check({31'h0, fetch_stall}, 32'h0);
    rd(fccd_pkg::ADDR_PREFETCH, 32'hc);
    prefetch_halfwords <= 6'h01;
    wr(fccd_pkg::ADDR_INSTR, 32'hb813);
    repeat (3) @(posedge pclk);
    check({31'h0, fetch_stall}, 32'h1);
    prefetch_halfwords <= 6'h02;
    repeat (3) @(posedge pclk);
    check({31'h0, fetch_stall}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(fccd_pkg::ADDR_INSTR, {16'h0, cs[k]});
      check({31'h0, fetch_stall}, 32'h0);
      xfer(fccd_pkg::ADDR_DECODE, 1'b0, 32'h0, 1'b0);
      check(r & 32'h1f00, k[0] ? 32'h800 : 32'h1800);
    end
    wr(fccd_pkg::ADDR_INSTR, 32'h1234);
    check({31'h0, emu_req}, 32'h0);
    stop_test();
  end
endmodule
